// >>> bench/char_lcd_host_instruction_unit_tb.sv
// self-checking bench of the instruction unit, driven through the host model.
// assumes short power-on and clear counts set by parameter.
module char_lcd_host_instruction_unit_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        busy_indication;
	logic        bus_width_select;
	logic        display_on;
	logic        cursor_on;
	logic        blink_on;
	logic        two_lines;
	logic        font_tall;
	logic        glyph_sel;
	logic [6:0]  cursor_addr;
	logic [6:0]  shift_offset;
	int          errors;
	int          total_checks;

	////////////////////////////////////////////////////////////////////////////////
	clhi_unit #(.POR_CYCLES(200), .CLEAR_CYCLES(200)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .busy_indication(busy_indication),
		.bus_width_select(bus_width_select), .display_on(display_on),
		.cursor_on(cursor_on), .blink_on(blink_on), .two_lines(two_lines),
		.font_tall(font_tall), .glyph_sel(glyph_sel), .cursor_addr(cursor_addr),
		.shift_offset(shift_offset)
	);

	clhi_host i_host (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr)
	);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// extra cycles cover the counter step that lands after busy clears
	task automatic wait_done(input int extra);
		int n;
		n = 0;
		@(negedge pclk);
		while (busy_indication !== 1'b0 && n < 100000) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 100000) errors++;
		repeat (extra) @(negedge pclk);
	endtask

	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] r);
		logic e;
		i_host.xfer(wr, a, {24'h000000, d}, r, e);
		chk(e, 1'b0);
		wait_done(310);
	endtask

	task automatic nib_wr(input logic [7:0] b);
		logic [31:0] r;
		logic        e;
		i_host.xfer(1'b1, 8'h00, {24'h000000, b[7:4], 4'h0}, r, e);
		chk(e, 1'b0);
		i_host.xfer(1'b1, 8'h00, {24'h000000, b[3:0], 4'h0}, r, e);
		chk(e, 1'b0);
		wait_done(310);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		chk(busy_indication, 1'b1);
		chk(bus_width_select, 1'b1);
		chk({display_on, cursor_on, blink_on, two_lines, font_tall}, 5'h00);
		@(posedge pclk);
		presetn <= 1'b1;
		i_host.xfer(1'b0, 8'h00, 32'h0, r, e);
		chk({e, r[7]}, 2'h1);
		i_host.xfer(1'b1, 8'h04, 32'h41, r, e);
		chk(e, 1'b1);
		wait_done(10);
		$display("test reset done");
	endtask

	task automatic t_data();
		logic [31:0] r;
		logic        e;
		i_host.xfer(1'b1, 8'h04, 32'h41, r, e);
		chk(e, 1'b0);
		wait_done(0);
		i_host.xfer(1'b0, 8'h00, 32'h0, r, e);
		chk(r[6:0], 7'h00);
		wait_done(310);
		chk(cursor_addr, 7'h01);
		acc(1'b1, 8'h00, 8'h80, r);
		acc(1'b0, 8'h04, 8'h00, r);
		chk(r[7:0], 8'h41);
		acc(1'b0, 8'h04, 8'h00, r);
		chk(r[7:0], 8'h20);
		chk(cursor_addr, 7'h02);
		$display("test data done");
	endtask

	task automatic t_ctrl();
		logic [31:0] r;
		acc(1'b1, 8'h00, 8'h0F, r);
		chk({display_on, cursor_on, blink_on}, 3'h7);
		acc(1'b1, 8'h00, 8'h04, r);
		acc(1'b1, 8'h04, 8'h55, r);
		chk(cursor_addr, 7'h01);
		acc(1'b1, 8'h00, 8'h06, r);
		acc(1'b1, 8'h00, 8'h18, r);
		chk(shift_offset, 7'h01);
		acc(1'b1, 8'h00, 8'h14, r);
		chk(cursor_addr, 7'h02);
		acc(1'b1, 8'h00, 8'h02, r);
		chk({shift_offset, cursor_addr}, 14'h0000);
		acc(1'b0, 8'h04, 8'h00, r);
		chk(r[7:0], 8'h41);
		$display("test control done");
	endtask

	task automatic t_glyph();
		logic [31:0] r;
		acc(1'b1, 8'h00, 8'h45, r);
		chk({glyph_sel, cursor_addr}, 8'h85);
		acc(1'b1, 8'h04, 8'h1F, r);
		acc(1'b1, 8'h00, 8'h45, r);
		acc(1'b0, 8'h04, 8'h00, r);
		chk(r[7:0], 8'h1F);
		chk(cursor_addr, 7'h06);
		acc(1'b1, 8'h00, 8'h80, r);
		chk(glyph_sel, 1'b0);
		$display("test glyph done");
	endtask

	task automatic t_nibble();
		logic [31:0] r;
		logic        e;
		acc(1'b1, 8'h00, 8'h20, r);
		chk(bus_width_select, 1'b0);
		nib_wr(8'h92);
		chk(cursor_addr, 7'h12);
		i_host.xfer(1'b0, 8'h00, 32'h0, r, e);
		chk(r[7:4], 4'h1);
		i_host.xfer(1'b0, 8'h00, 32'h0, r, e);
		chk(r[7:4], 4'h2);
		// two-line bit asked for here, but line count is frozen by now
		nib_wr(8'h38);
		chk(bus_width_select, 1'b1);
		chk(two_lines, 1'b0);
		acc(1'b0, 8'h00, 8'h00, r);
		chk(r[7:0], 8'h12);
		$display("test nibble done");
	endtask

	task automatic t_clear();
		logic [31:0] r;
		logic        e;
		acc(1'b1, 8'h00, 8'h01, r);
		chk(cursor_addr, 7'h00);
		acc(1'b0, 8'h04, 8'h00, r);
		chk(r[7:0], 8'h20);
		i_host.xfer(1'b0, 8'h0C, 32'h0, r, e);
		chk(e, 1'b1);
		chk(r, 32'h0000_0000);
		i_host.xfer(1'b0, 8'h08, 32'h0, r, e);
		chk({e, r[5]}, 2'h1);
		$display("test clear and map done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		errors = 0;
		total_checks = 0;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		t_reset();
		t_data();
		t_ctrl();
		t_glyph();
		t_nibble();
		t_clear();
		wrap_up();
	end

	// about 22 commands of some 2300 cycles each, with margin
	initial begin
		repeat (80000) @(posedge pclk);
		errors++;
		wrap_up();
	end
endmodule

// >>> bench/clhi_host.sv
// partner model: the host controller issuing apb transfers to the unit.
// assumes a free-running pclk; the bench calls xfer hierarchically.
module clhi_host (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb master
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h00000000;
	end

	// request held until pready is seen high at a rising edge; answer taken there
	// no wait limit here: only the bench watchdog ends a hung transfer
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// >>> rtl/clhi_pkg.sv
// constants shared by the character display instruction unit and its memories.
// assumes a single 50 MHz apb clock; execution times scale from a 250 kHz reference.
package clhi_pkg;
	// apb register offsets (byte addresses)
	localparam logic [7:0] ADDR_INSTR = 8'h00;
	localparam logic [7:0] ADDR_DATA  = 8'h04;
	localparam logic [7:0] ADDR_STATE = 8'h08;

	// timing, each figure in its own unit
	localparam int CLK_MHZ          = 50;
	localparam int REF_KHZ          = 250;
	localparam int EXEC_US          = 40;
	localparam int CLEAR_US         = 1640;
	localparam int POR_MS           = 10;
	localparam int ADD_HALF_PERIODS = 3;

	// memory geometry and line layout
	localparam int TEXT_AW  = 7;
	localparam int GLYPH_AW = 6;
	localparam logic [7:0] SPACE_CODE = 8'h20;
	localparam logic [6:0] LINE1_LEN  = 7'h50;
	localparam logic [6:0] LINE2_LEN  = 7'h28;
	localparam logic [6:0] LINE2_BASE = 7'h40;
	localparam logic [6:0] LAST_ADDR  = 7'h7F;

	// reset values of the display state
	localparam logic RST_BUS_WIDE = 1'b1;
	localparam logic RST_TWO      = 1'b0;
	localparam logic RST_TALL     = 1'b0;
	localparam logic RST_DISP     = 1'b0;
	localparam logic RST_INC      = 1'b1;
	localparam logic RST_SHIFT    = 1'b0;

	// state word field positions
	localparam int FLD_DISP   = 0;
	localparam int FLD_CURS   = 1;
	localparam int FLD_BLINK  = 2;
	localparam int FLD_TWO    = 3;
	localparam int FLD_TALL   = 4;
	localparam int FLD_WIDE   = 5;
	localparam int FLD_INC    = 6;
	localparam int FLD_ESHIFT = 7;
	localparam int FLD_GLYPH  = 8;
	localparam int FLD_BUSY   = 9;
	localparam int FLD_OFFSET = 16;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_EXEC   = 2'b01,
		ST_UPDATE = 2'b10,
		ST_POR    = 2'b11
	} clhi_state_t;
endpackage

// >>> rtl/clhi_ram.sv
// simple dual port byte memory with registered read data.
// assumes one clock; no reset, text contents are set by the owner's clear sweep, glyph contents only by data writes.
module clhi_ram #(
	parameter int AW = 7,
	parameter int DW = 8
) (
	// clock
	input  wire logic          clk,
	// write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	// read port
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// >>> rtl/clhi_unit.sv
// instruction and data unit of a character display controller, apb slave.
// assumes the host polls busy; instruction writes and data accesses made while busy are refused with pslverr.
module clhi_unit #(
	parameter int OSC_KHZ      = clhi_pkg::REF_KHZ,
	parameter int POR_CYCLES   = clhi_pkg::POR_MS * 1000 * clhi_pkg::CLK_MHZ,
	parameter int CLEAR_CYCLES = clhi_pkg::CLEAR_US * clhi_pkg::CLK_MHZ
		* clhi_pkg::REF_KHZ / OSC_KHZ
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// display state
	output logic             busy_indication,
	output logic             bus_width_select,
	output logic             display_on,
	output logic             cursor_on,
	output logic             blink_on,
	output logic             two_lines,
	output logic             font_tall,
	output logic             glyph_sel,
	output logic      [6:0]  cursor_addr,
	output logic      [6:0]  shift_offset
);
	localparam int EXEC_CYCLES = clhi_pkg::EXEC_US * clhi_pkg::CLK_MHZ
		* clhi_pkg::REF_KHZ / OSC_KHZ;
	localparam int ADD_CYCLES  = clhi_pkg::ADD_HALF_PERIODS * clhi_pkg::CLK_MHZ
		* 1000 / (2 * OSC_KHZ);
	localparam int CNT_W = $clog2(POR_CYCLES + CLEAR_CYCLES + EXEC_CYCLES + 1);

	clhi_pkg::clhi_state_t state;
	logic [CNT_W-1:0]      cnt;
	logic                  upd_pending;
	logic                  entry_inc;
	logic                  entry_shift;
	logic                  func_lock;
	logic                  nib_lo;
	logic [3:0]            nib_hold;
	logic [7:0]            rd_hold;
	logic                  req_ok;
	logic                  req_instr;
	logic                  req_data;
	logic                  sweep_on;
	logic [6:0]            sweep_addr;
	logic [7:0]            text_q;
	logic [7:0]            glyph_q;
	logic [31:0]           state_word;

	////////////////////////////////////////////////////////////////////////
	// address stepping helpers

	function automatic logic [6:0] clhi_step(input logic [6:0] a, input logic up,
		input logic glyph, input logic two);
		logic [6:0] r;
		r = up ? a + 7'h01 : a - 7'h01;
		if (glyph) begin
			r[6] = 1'b0;
		end else if (!two) begin
			if (up && a == clhi_pkg::LINE1_LEN - 7'h01) r = 7'h00;
			else if (!up && a == 7'h00) r = clhi_pkg::LINE1_LEN - 7'h01;
		end else begin
			if (up && a == clhi_pkg::LINE2_LEN - 7'h01) r = clhi_pkg::LINE2_BASE;
			else if (up && a == clhi_pkg::LINE2_BASE + clhi_pkg::LINE2_LEN - 7'h01) r = 7'h00;
			else if (!up && a == 7'h00) r = clhi_pkg::LINE2_BASE + clhi_pkg::LINE2_LEN - 7'h01;
			else if (!up && a == clhi_pkg::LINE2_BASE) r = clhi_pkg::LINE2_LEN - 7'h01;
		end
		return r;
	endfunction

	// offset counts positions the picture is moved left, within one line
	function automatic logic [6:0] clhi_rot(input logic [6:0] o, input logic left,
		input logic two);
		logic [6:0] len;
		len = two ? clhi_pkg::LINE2_LEN : clhi_pkg::LINE1_LEN;
		if (left) return (o == len - 7'h01) ? 7'h00 : o + 7'h01;
		return (o == 7'h00) ? len - 7'h01 : o - 7'h01;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// apb decode

	wire setup    = psel & ~penable;
	wire access   = psel & penable & pready;
	wire a_instr  = paddr == clhi_pkg::ADDR_INSTR;
	wire a_data   = paddr == clhi_pkg::ADDR_DATA;
	wire a_state  = paddr == clhi_pkg::ADDR_STATE;
	wire stat_rd  = a_instr & ~pwrite;
	wire ok       = a_state
		| ((a_instr | a_data) & (stat_rd | state == clhi_pkg::ST_IDLE));
	wire [7:0] wbyte = bus_width_select ? pwdata[7:0] : {nib_hold, pwdata[7:4]};
	wire go       = access & req_ok & (bus_width_select | nib_lo);
	wire cmd_wr   = go & pwrite & req_instr;
	wire dat_wr   = go & pwrite & req_data;
	wire dat_rd   = go & ~pwrite & req_data;
	wire [7:0] status_byte = {busy_indication, cursor_addr};
	wire [7:0] data_byte   = glyph_sel ? glyph_q : text_q;
	wire [7:0] rbyte       = a_instr ? status_byte : data_byte;

	// opcode is the highest set bit
	wire is_clear = cmd_wr & (wbyte == 8'h01);
	wire is_home  = cmd_wr & (wbyte[7:1] == 7'h01);
	wire is_entry = cmd_wr & (wbyte[7:2] == 6'h01);
	wire is_ctl   = cmd_wr & (wbyte[7:3] == 5'h01);
	wire is_shift = cmd_wr & (wbyte[7:4] == 4'h1);
	wire is_func  = cmd_wr & (wbyte[7:5] == 3'h1);
	wire is_cga   = cmd_wr & (wbyte[7:6] == 2'h1);
	wire is_dda   = cmd_wr & wbyte[7];

	always_comb begin
		state_word = 32'h0000_0000;
		state_word[clhi_pkg::FLD_DISP]   = display_on;
		state_word[clhi_pkg::FLD_CURS]   = cursor_on;
		state_word[clhi_pkg::FLD_BLINK]  = blink_on;
		state_word[clhi_pkg::FLD_TWO]    = two_lines;
		state_word[clhi_pkg::FLD_TALL]   = font_tall;
		state_word[clhi_pkg::FLD_WIDE]   = bus_width_select;
		state_word[clhi_pkg::FLD_INC]    = entry_inc;
		state_word[clhi_pkg::FLD_ESHIFT] = entry_shift;
		state_word[clhi_pkg::FLD_GLYPH]  = glyph_sel;
		state_word[clhi_pkg::FLD_BUSY]   = busy_indication;
		state_word[clhi_pkg::FLD_OFFSET +: 7] = shift_offset;
	end

	////////////////////////////////////////////////////////////////////////
	// apb answer: zero wait states, response built in the setup cycle

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			prdata    <= 32'h0000_0000;
			req_ok    <= 1'b0;
			req_instr <= 1'b0;
			req_data  <= 1'b0;
			rd_hold   <= 8'h00;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~ok;
			if (setup) begin
				req_ok    <= ok;
				req_instr <= a_instr;
				req_data  <= a_data;
				if (!ok || pwrite) begin
					prdata <= 32'h0000_0000;
				end else if (a_state) begin
					prdata <= state_word;
				end else if (bus_width_select) begin
					prdata <= {24'h00_0000, rbyte};
				end else if (!nib_lo) begin
					// low half kept so both nibbles come from one sample
					prdata  <= {24'h00_0000, rbyte[7:4], 4'h0};
					rd_hold <= rbyte;
				end else begin
					prdata <= {24'h00_0000, rd_hold[3:0], 4'h0};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// nibble sequencer

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nib_lo   <= 1'b0;
			nib_hold <= 4'h0;
		end else begin
			if (access && req_ok && (req_instr || req_data) && !bus_width_select) begin
				nib_lo <= ~nib_lo;
				if (!nib_lo) nib_hold <= pwdata[7:4];
			end
			if (bus_width_select || is_func) begin
				nib_lo <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_width_select <= clhi_pkg::RST_BUS_WIDE;
			two_lines        <= clhi_pkg::RST_TWO;
			font_tall        <= clhi_pkg::RST_TALL;
			display_on       <= clhi_pkg::RST_DISP;
			cursor_on        <= clhi_pkg::RST_DISP;
			blink_on         <= clhi_pkg::RST_DISP;
			entry_inc        <= clhi_pkg::RST_INC;
			entry_shift      <= clhi_pkg::RST_SHIFT;
			func_lock        <= 1'b0;
		end else begin
			if (is_clear) entry_inc <= 1'b1;
			if (is_entry) begin
				entry_inc   <= wbyte[1];
				entry_shift <= wbyte[0];
			end
			if (is_ctl) begin
				display_on <= wbyte[2];
				cursor_on  <= wbyte[1];
				blink_on   <= wbyte[0];
			end
			if (is_func) begin
				bus_width_select <= wbyte[4];
				// line count and font freeze once another command runs
				if (!func_lock) begin
					two_lines <= wbyte[3];
					font_tall <= wbyte[2];
				end
			end else if (cmd_wr || dat_wr || dat_rd) begin
				func_lock <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address counter and display shift

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cursor_addr  <= 7'h00;
			glyph_sel    <= 1'b0;
			shift_offset <= 7'h00;
		end else begin
			if (is_clear || is_home) begin
				cursor_addr  <= 7'h00;
				glyph_sel    <= 1'b0;
				shift_offset <= 7'h00;
			end else if (is_cga) begin
				cursor_addr <= {1'b0, wbyte[5:0]};
				glyph_sel   <= 1'b1;
			end else if (is_dda) begin
				cursor_addr <= wbyte[6:0];
				glyph_sel   <= 1'b0;
			end else if (is_shift) begin
				if (wbyte[3]) shift_offset <= clhi_rot(shift_offset, ~wbyte[2], two_lines);
				else cursor_addr <= clhi_step(cursor_addr, wbyte[2], glyph_sel, two_lines);
			end else if (dat_wr && entry_shift && !glyph_sel) begin
				shift_offset <= clhi_rot(shift_offset, entry_inc, two_lines);
			end
			// cursor follows the counter in both memories
			if (state == clhi_pkg::ST_UPDATE && cnt == '0) begin
				cursor_addr <= clhi_step(cursor_addr, entry_inc, glyph_sel, two_lines);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// execution timer

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state           <= clhi_pkg::ST_POR;
			cnt             <= CNT_W'(POR_CYCLES - 1);
			upd_pending     <= 1'b0;
			busy_indication <= 1'b1;
		end else begin
			case (state)
				clhi_pkg::ST_POR: begin
					if (cnt == '0) begin
						state           <= clhi_pkg::ST_IDLE;
						busy_indication <= 1'b0;
					end else begin
						cnt <= cnt - CNT_W'(1);
					end
				end
				clhi_pkg::ST_IDLE: begin
					if (cmd_wr && wbyte != 8'h00) begin
						state           <= clhi_pkg::ST_EXEC;
						busy_indication <= 1'b1;
						cnt <= (is_clear || is_home) ? CNT_W'(CLEAR_CYCLES - 1)
							: CNT_W'(EXEC_CYCLES - 1);
					end else if (dat_wr || dat_rd) begin
						state           <= clhi_pkg::ST_EXEC;
						busy_indication <= 1'b1;
						upd_pending     <= 1'b1;
						cnt             <= CNT_W'(EXEC_CYCLES - 1);
					end
				end
				clhi_pkg::ST_EXEC: begin
					if (cnt == '0) begin
						busy_indication <= 1'b0;
						upd_pending     <= 1'b0;
						if (upd_pending) begin
							state <= clhi_pkg::ST_UPDATE;
							cnt   <= CNT_W'(ADD_CYCLES - 1);
						end else begin
							state <= clhi_pkg::ST_IDLE;
						end
					end else begin
						cnt <= cnt - CNT_W'(1);
					end
				end
				clhi_pkg::ST_UPDATE: begin
					if (cnt == '0) state <= clhi_pkg::ST_IDLE;
					else cnt <= cnt - CNT_W'(1);
				end
				default: begin
					state <= clhi_pkg::ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clear sweep: fills text memory with blanks, also after reset

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sweep_on   <= 1'b1;
			sweep_addr <= 7'h00;
		end else if (is_clear) begin
			sweep_on   <= 1'b1;
			sweep_addr <= 7'h00;
		end else if (sweep_on) begin
			sweep_addr <= sweep_addr + 7'h01;
			if (sweep_addr == clhi_pkg::LAST_ADDR) sweep_on <= 1'b0;
		end
	end

	clhi_ram #(
		.AW (clhi_pkg::TEXT_AW),
		.DW (8)
	) u_text (
		.clk   (pclk),
		.we    (sweep_on | (dat_wr & ~glyph_sel)),
		.waddr (sweep_on ? sweep_addr : cursor_addr),
		.wdata (sweep_on ? clhi_pkg::SPACE_CODE : wbyte),
		.raddr (cursor_addr),
		.rdata (text_q)
	);

	clhi_ram #(
		.AW (clhi_pkg::GLYPH_AW),
		.DW (8)
	) u_glyph (
		.clk   (pclk),
		.we    (dat_wr & glyph_sel),
		.waddr (cursor_addr[5:0]),
		.wdata (wbyte),
		.raddr (cursor_addr[5:0]),
		.rdata (glyph_q)
	);

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence data_go_s;
		dat_wr || dat_rd;
	endsequence

	sequence addr_held_s;
		$stable(cursor_addr) [*8];
	endsequence

	apb_answer_a: assert property (setup |=> pready ##1 !pready)
		else $error("apb answer not one cycle after setup");
	busy_refuse_a: assert property (
		setup && (a_data || (a_instr && pwrite)) && state != clhi_pkg::ST_IDLE
		|=> pready && pslverr)
		else $error("access while busy not refused");
	status_pass_a: assert property (
		setup && stat_rd && bus_width_select
		|=> !pslverr && prdata[7:0] == {$past(busy_indication), $past(cursor_addr)})
		else $error("status read wrong");
	por_busy_a: assert property (state == clhi_pkg::ST_POR |-> busy_indication)
		else $error("busy dropped during power-on");
	clear_home_a: assert property (
		is_clear |=> cursor_addr == 7'h00 && !glyph_sel && entry_inc && busy_indication
		&& sweep_on)
		else $error("clear did not home");
	ac_defer_a: assert property (data_go_s |=> busy_indication and addr_held_s)
		else $error("address moved before busy cleared");
	nibble_hi_a: assert property (
		access && req_ok && (req_instr || req_data) && pwrite && !bus_width_select && !nib_lo
		|=> nib_lo && state == clhi_pkg::ST_IDLE && nib_hold == $past(pwdata[7:4]))
		else $error("first nibble not held");
	width_restart_a: assert property (is_func |=> !nib_lo)
		else $error("nibble phase not restarted");
	entry_mode_a: assert property (
		is_entry |=> entry_inc == $past(wbyte[1]) && entry_shift == $past(wbyte[0]))
		else $error("entry mode not stored");
	disp_ctl_a: assert property (
		is_ctl |=> {display_on, cursor_on, blink_on} == $past(wbyte[2:0]))
		else $error("display control not stored");
	glyph_addr_a: assert property (
		is_cga |=> glyph_sel && cursor_addr == {1'b0, $past(wbyte[5:0])})
		else $error("glyph address not loaded");
	text_addr_a: assert property (is_dda |=> !glyph_sel && cursor_addr == $past(wbyte[6:0]))
		else $error("text address not loaded");
	func_set_a: assert property (is_func |=> bus_width_select == $past(wbyte[4]))
		else $error("bus width not set");
endmodule
